// >>> rtl/acs_defines.vh
// Purpose: constants of the converter calibration sequencer
// Assumes: 8-bit registers on a plain strobe port
// Notes: offsets are byte indices of the local register port
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH
// ****************************************
// register offsets
// ****************************************
`define ACS_ADDR_RES_HIGH    3'h0
`define ACS_ADDR_RES_LOW     3'h1
`define ACS_ADDR_CTRL_MAIN   3'h2
`define ACS_ADDR_CTRL_REF    3'h3
`define ACS_ADDR_CTRL_TIME   3'h4
`define ACS_ADDR_IRQ_STATUS  3'h5
`define ACS_ADDR_IRQ_MASK    3'h6
// ****************************************
// field positions
// ****************************************
`define ACS_BIT_CAL          7
`define ACS_BIT_GO           1
`define ACS_BIT_POWER        0
`define ACS_BIT_JUSTIFY      7
`define ACS_ACQ_HI           5
`define ACS_ACQ_LO           3
`define ACS_IRQ_DONE         0
`define ACS_IRQ_CAL          1
// ****************************************
// reset values and masks
// ****************************************
`define ACS_RST_CTRL_MAIN    8'h00
`define ACS_RST_CTRL_REF     8'h00
`define ACS_RST_CTRL_TIME    8'h00
`define ACS_MASK_CTRL_MAIN   8'hbf
`define ACS_MASK_CTRL_REF    8'h3f
`define ACS_MASK_CTRL_TIME   8'hbf
`define ACS_MASK_IRQ         8'h03
`define ACS_ACQ_ZERO         3'h0
// ****************************************
// timing
// ****************************************
`define ACS_CLK_MHZ          25
`define ACS_INSTR_NS         160
`define ACS_INSTR_CYCLES     ((`ACS_INSTR_NS * `ACS_CLK_MHZ) / 1000)
`endif

// >>> rtl/acs_offset_store.v
// Purpose: hidden offset store written by the dummy conversion
// Assumes: single clock, synchronous reset
// Notes: read data come out of a register
module acs_offset_store #(
	parameter WIDTH = 10
) (
	// clock and reset
	input  wire             clk,
	input  wire             rst,
	// write side
	input  wire             wr_en,
	input  wire [WIDTH-1:0] wr_data,
	// read side
	output reg  [WIDTH-1:0] rd_data,
	output reg              valid
);
	always @(posedge clk) begin
		if (rst) begin
			rd_data <= {WIDTH{1'b0}};
			valid   <= 1'b0;
		end else if (wr_en) begin
			rd_data <= wr_data;
			valid   <= 1'b1;
		end
	end
endmodule

// >>> rtl/acs_corrector.v
// Purpose: subtract stored offset from a raw sample, clamped at zero
// Assumes: raw and offset share one width
// Notes: registered output
module acs_corrector #(
	parameter WIDTH = 10
) (
	// clock and reset
	input  wire             clk,
	input  wire             rst,
	// operands
	input  wire             load,
	input  wire             use_offset,
	input  wire [WIDTH-1:0] raw,
	input  wire [WIDTH-1:0] offset,
	// result
	output reg  [WIDTH-1:0] result
);
	wire [WIDTH:0] diff;
	assign diff = {1'b0, raw} - {1'b0, offset};
	always @(posedge clk) begin
		if (rst) begin
			result <= {WIDTH{1'b0}};
		end else if (load) begin
			if (!use_offset)
				result <= raw;
			else if (diff[WIDTH])
				result <= {WIDTH{1'b0}};
			else
				result <= diff[WIDTH-1:0];
		end
	end
endmodule

// >>> rtl/acs_sequencer.v
// Contract
// - setting the calibrate request bit arms offset self-calibration.
// - next trigger while calibration armed runs a dummy conversion, no channel sampled.
// - dummy result kept in a hidden offset store.
// - later conversions are corrected by the stored offset.
// - zero acquisition time delays conversion start by one instruction cycle.
// - result shown as high byte and low byte registers.
//
// Purpose: control of the converter: calibration, start timing, result and irq
// Assumes: analog core answers a start with a done pulse and a raw sample
// Notes: status register clears on read; set wins over the clear
`include "acs_defines.vh"
module acs_sequencer #(
	parameter WIDTH      = 10,
	parameter ACQ_CYCLES = 4
) (
	// clock and reset
	input  wire             clk,
	input  wire             rst,
	// register port
	input  wire [2:0]       reg_addr,
	input  wire [7:0]       reg_wdata,
	input  wire             reg_wr,
	input  wire             reg_rd,
	output reg  [7:0]       reg_rdata,
	// analog core
	output reg              conv_start,
	output reg              conv_dummy,
	output reg  [3:0]       conv_channel,
	output reg  [2:0]       conv_clock_select,
	output reg              conv_power,
	input  wire             conv_done,
	input  wire [WIDTH-1:0] conv_raw,
	// interrupt
	output reg              irq
);
	// ****************************************
	// states
	// ****************************************
	localparam ST_IDLE  = 2'h0;
	localparam ST_DELAY = 2'h1;
	localparam ST_ACQ   = 2'h2;
	localparam ST_CONV  = 2'h3;
	localparam DLY_W    = 8;
	localparam integer     INSTR_RAW = (`ACS_INSTR_CYCLES < 1) ? 1 : `ACS_INSTR_CYCLES;
	localparam [DLY_W-1:0] INSTR_CNT = INSTR_RAW[DLY_W-1:0];
	localparam [DLY_W-1:0] ACQ_CNT   = ACQ_CYCLES[DLY_W-1:0];

	// ****************************************
	// registers
	// ****************************************
	reg  [7:0]       ctrl_main;
	reg  [7:0]       ctrl_ref;
	reg  [7:0]       ctrl_time;
	reg  [1:0]       irq_status;
	reg  [1:0]       irq_mask;
	reg  [1:0]       state;
	reg  [DLY_W-1:0] dly;
	reg              cal_run;
	reg              done_d;
	reg              dummy_d;
	wire [WIDTH-1:0] offset_value;
	wire             offset_valid;
	wire [WIDTH-1:0] corrected;
	wire             wr_main;
	wire [15:0]      res_word;
	reg  [1:0]       next_status;

	assign wr_main  = reg_wr && (reg_addr == `ACS_ADDR_CTRL_MAIN);

	// ****************************************
	// offset store and correction
	// ****************************************
	acs_offset_store #(.WIDTH(WIDTH)) u_store (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (conv_done && cal_run),
		.wr_data (conv_raw),
		.rd_data (offset_value),
		.valid   (offset_valid)
	);

	acs_corrector #(.WIDTH(WIDTH)) u_corr (
		.clk        (clk),
		.rst        (rst),
		.load       (conv_done && !cal_run),
		.use_offset (offset_valid),
		.raw        (conv_raw),
		.offset     (offset_value),
		.result     (corrected)
	);

	// result layout: right or left justified
	assign res_word = ctrl_time[`ACS_BIT_JUSTIFY] ?
		{{(16-WIDTH){1'b0}}, corrected} : {corrected, {(16-WIDTH){1'b0}}};

	// ****************************************
	// control registers and sequence
	// ****************************************
	always @(posedge clk) begin
		if (rst) begin
			ctrl_main  <= `ACS_RST_CTRL_MAIN;
			ctrl_ref   <= `ACS_RST_CTRL_REF;
			ctrl_time  <= `ACS_RST_CTRL_TIME;
			irq_mask   <= 2'h0;
			state      <= ST_IDLE;
			dly        <= {DLY_W{1'b0}};
			cal_run    <= 1'b0;
			conv_start <= 1'b0;
			conv_dummy <= 1'b0;
			done_d     <= 1'b0;
			dummy_d    <= 1'b0;
		end else begin
			conv_start <= 1'b0;
			done_d     <= conv_done && state == ST_CONV;
			dummy_d    <= cal_run;
			if (reg_wr && reg_addr == `ACS_ADDR_CTRL_REF)
				ctrl_ref <= reg_wdata & `ACS_MASK_CTRL_REF;
			if (reg_wr && reg_addr == `ACS_ADDR_CTRL_TIME)
				ctrl_time <= reg_wdata & `ACS_MASK_CTRL_TIME;
			if (reg_wr && reg_addr == `ACS_ADDR_IRQ_MASK)
				irq_mask <= reg_wdata[1:0];
			if (wr_main)
				ctrl_main <= reg_wdata & `ACS_MASK_CTRL_MAIN;
			case (state)
			ST_IDLE: begin
				if (wr_main && reg_wdata[`ACS_BIT_GO] && reg_wdata[`ACS_BIT_POWER]) begin
					cal_run <= reg_wdata[`ACS_BIT_CAL];
					if (ctrl_time[`ACS_ACQ_HI:`ACS_ACQ_LO] == `ACS_ACQ_ZERO) begin
						state <= ST_DELAY;
						dly   <= INSTR_CNT;
					end else begin
						state <= ST_ACQ;
						dly   <= ACQ_CNT;
					end
				end
			end
			ST_DELAY, ST_ACQ: begin
				if (dly <= 8'h01) begin
					state      <= ST_CONV;
					conv_start <= 1'b1;
					conv_dummy <= cal_run;
				end else begin
					dly <= dly - 8'h01;
				end
			end
			ST_CONV: begin
				if (conv_done) begin
					state                   <= ST_IDLE;
					ctrl_main[`ACS_BIT_GO]  <= 1'b0;
					if (cal_run)
						ctrl_main[`ACS_BIT_CAL] <= 1'b0;
					cal_run    <= 1'b0;
					conv_dummy <= 1'b0;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// analog side outputs
	// ****************************************
	always @(posedge clk) begin
		if (rst) begin
			conv_channel      <= 4'h0;
			conv_clock_select <= 3'h0;
			conv_power        <= 1'b0;
		end else begin
			conv_channel      <= ctrl_main[5:2];
			conv_clock_select <= ctrl_time[2:0];
			conv_power        <= ctrl_main[`ACS_BIT_POWER];
		end
	end

	// ****************************************
	// interrupt status, mask, output
	// ****************************************
	always @* begin
		next_status = irq_status;
		if (reg_rd && reg_addr == `ACS_ADDR_IRQ_STATUS)
			next_status = 2'h0;
		if (done_d)
			next_status[`ACS_IRQ_DONE] = 1'b1;
		if (done_d && dummy_d)
			next_status[`ACS_IRQ_CAL] = 1'b1;
	end

	always @(posedge clk) begin
		if (rst) begin
			irq_status <= 2'h0;
			irq        <= 1'b0;
		end else begin
			irq_status <= next_status;
			irq        <= |(next_status & irq_mask);
		end
	end

	// ****************************************
	// read port
	// ****************************************
	always @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
			`ACS_ADDR_RES_HIGH:   reg_rdata <= res_word[15:8];
			`ACS_ADDR_RES_LOW:    reg_rdata <= res_word[7:0];
			`ACS_ADDR_CTRL_MAIN:  reg_rdata <= ctrl_main;
			`ACS_ADDR_CTRL_REF:   reg_rdata <= ctrl_ref;
			`ACS_ADDR_CTRL_TIME:  reg_rdata <= ctrl_time;
			`ACS_ADDR_IRQ_STATUS: reg_rdata <= {6'h00, irq_status};
			`ACS_ADDR_IRQ_MASK:   reg_rdata <= {6'h00, irq_mask};
			default:              reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule

// >>> verif/acs_sequencer_properties.sv
// Purpose: port checks of the sequencer
// Assumes: one clock, sync reset
// Notes: busy follows accepted starts
`include "acs_defines.vh"
module acs_sequencer_properties #(
	parameter WIDTH      = 10,
	parameter ACQ_CYCLES = 4
) (
	// clock, reset
	input wire             clk,
	input wire             rst,
	// registers
	input wire [2:0]       reg_addr,
	input wire [7:0]       reg_wdata,
	input wire             reg_wr,
	input wire             reg_rd,
	input wire [7:0]       reg_rdata,
	// core
	input wire             conv_start,
	input wire             conv_dummy,
	input wire [3:0]       conv_channel,
	input wire [2:0]       conv_clock_select,
	input wire             conv_power,
	input wire             conv_done,
	input wire [WIDTH-1:0] conv_raw,
	// irq
	input wire             irq
);
	logic busy;
	logic go_wr;
	assign go_wr = reg_wr && reg_addr == 3'h2 && reg_wdata[1] && reg_wdata[0] && !busy;
	always @(posedge clk) begin
		if (rst || conv_done)
			busy <= 1'b0;
		else if (go_wr)
			busy <= 1'b1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_start; go_wr |-> ##5 conv_start; endproperty
	property p_cal; go_wr && reg_wdata[7] |-> ##5 conv_dummy; endproperty
	property p_plain; go_wr && !reg_wdata[7] |-> ##5 !conv_dummy; endproperty
	property p_dum_end; conv_dummy && conv_done |=> !conv_dummy; endproperty
	property p_pulse; conv_start |=> !conv_start; endproperty
	property p_power; conv_start |-> conv_power && busy; endproperty
	property p_unmap; reg_rd && reg_addr == 3'h7 |=> reg_rdata == 8'h00; endproperty
	property p_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
	a_start: assert property (p_start) else $error("late start");
	a_cal: assert property (p_cal) else $error("no dummy");
	a_plain: assert property (p_plain) else $error("stray dummy");
	a_dum_end: assert property (p_dum_end) else $error("dummy stuck");
	a_pulse: assert property (p_pulse) else $error("long start");
	a_power: assert property (p_power) else $error("bad start");
	a_unmap: assert property (p_unmap) else $error("unmapped data");
	a_idle: assert property (p_idle) else $error("stray data");
	c_cal: cover property (go_wr && reg_wdata[7]);
	c_dum: cover property (conv_dummy && conv_done);
	c_irq: cover property ($rose(irq));
endmodule

// >>> verif/testbench.sv
// Purpose: directed bench of the sequencer
// Assumes: bench plays the analog core
// Notes: offset seen through result bytes
`include "acs_defines.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 0;
	logic       rst = 1;
	logic [2:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0;
	logic       reg_wr = 0;
	logic       reg_rd = 0;
	logic [7:0] reg_rdata;
	logic       conv_start, conv_dummy, conv_power, irq;
	logic [3:0] conv_channel;
	logic [2:0] conv_clock_select;
	logic       conv_done = 0;
	logic [9:0] conv_raw = 0;
	int         n_errors = 0;
	int         comparisons = 0;
	acs_sequencer DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start),
		.conv_dummy(conv_dummy), .conv_channel(conv_channel), .conv_clock_select(conv_clock_select),
		.conv_power(conv_power),
		.conv_done(conv_done), .conv_raw(conv_raw), .irq(irq));
	initial forever #20 clk = ~clk;
	task automatic summarize();
		if (n_errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 0;
		#1 chk(reg_rdata, exp);
	endtask
	task automatic convert(input logic [7:0] ctl, input logic [9:0] raw);
		int n;
		wr(3'h2, ctl);
		for (n = 0; n < 20 && conv_start !== 1'b1; n++)
			@(posedge clk) #1;
		if (conv_start !== 1'b1) begin
			n_errors++;
			summarize();
		end
		chk(n[7:0], 8'(`ACS_INSTR_CYCLES));
		chk({7'h00, conv_dummy}, {7'h00, ctl[7]});
		@(posedge clk);
		conv_done <= 1;
		conv_raw <= raw;
		@(posedge clk);
		conv_done <= 0;
		repeat (3) @(posedge clk);
		rd(3'h2, ctl & 8'h3d);
	endtask
	task automatic t_regs();
		rd(3'h2, 8'h00);
		rd(3'h4, 8'h00);
		wr(3'h3, 8'hff);
		rd(3'h3, 8'h3f);
		rd(3'h7, 8'h00);
	endtask
	task automatic t_first();
		convert(8'h03, 10'h2c5);
		chk(irq, 0);
		rd(3'h0, 8'hb1);
		rd(3'h1, 8'h40);
		rd(3'h5, 8'h01);
		rd(3'h5, 8'h00);
	endtask
	task automatic t_cal();
		wr(3'h4, 8'h97);
		convert(8'h83, 10'h005);
		rd(3'h0, 8'h02);
		rd(3'h1, 8'hc5);
		rd(3'h5, 8'h03);
		chk({5'h00, conv_clock_select}, 8'h07);
		convert(8'h07, 10'h123);
		chk({4'h0, conv_channel}, 8'h01);
		rd(3'h0, 8'h01);
		rd(3'h1, 8'h1e);
		convert(8'h03, 10'h003);
		rd(3'h0, 8'h00);
		rd(3'h1, 8'h00);
	endtask
	task automatic t_irq();
		wr(3'h6, 8'h01);
		convert(8'h03, 10'h010);
		chk(irq, 1);
		rd(3'h5, 8'h01);
		@(posedge clk) #1 chk(irq, 0);
		wr(3'h2, 8'h02);
		repeat (8) @(posedge clk) #1 chk(conv_start, 0);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		t_regs();
		t_first();
		t_cal();
		t_irq();
		summarize();
	end
endmodule
bind acs_sequencer acs_sequencer_properties #(.WIDTH(WIDTH), .ACQ_CYCLES(ACQ_CYCLES)) u_chk (.clk(clk),
	.rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .conv_start(conv_start), .conv_dummy(conv_dummy), .conv_channel(conv_channel),
	.conv_clock_select(conv_clock_select), .conv_power(conv_power), .conv_done(conv_done),
	.conv_raw(conv_raw), .irq(irq));
